// File: rtl/pump_err_pkg.sv
package pump_err_pkg;

    // Command classes delivered by the command parser.
    typedef enum logic [3:0] {
        CMD_BAD,
        CMD_QUERY,
        CMD_REPORT,
        CMD_CONTROL,
        CMD_TOP_SPEED,
        CMD_INIT,
        CMD_MOVE,
        CMD_VALVE,
        CMD_SET
    } cmd_class_t;

    // One decoded command with its operand check and value.
    typedef struct packed {
        cmd_class_t  cls;
        logic        operand_ok;
        logic [13:0] value;
    } cmd_t;

    // Fault and completion pulses from the motion and support logic.
    typedef struct packed {
        logic init_ok;
        logic init_fail;
        logic plunger_ovl;
        logic valve_ovl;
        logic eeprom_fail;
        logic internal_fail;
        logic adc_fail;
    } fault_t;

    // Error codes placed in the low nibble of the status byte.
    localparam logic [3:0] ERR_NONE        = 4'h0;
    localparam logic [3:0] ERR_INIT        = 4'h1;
    localparam logic [3:0] ERR_BAD_CMD     = 4'h2;
    localparam logic [3:0] ERR_BAD_OPERAND = 4'h3;
    localparam logic [3:0] ERR_EEPROM      = 4'h6;
    localparam logic [3:0] ERR_NOT_INIT    = 4'h7;
    localparam logic [3:0] ERR_INTERNAL    = 4'h8;
    localparam logic [3:0] ERR_PLUNGER_OVL = 4'h9;
    localparam logic [3:0] ERR_VALVE_OVL   = 4'hA;
    localparam logic [3:0] ERR_NO_PLUNGER  = 4'hB;
    localparam logic [3:0] ERR_FAILURE     = 4'hC;
    localparam logic [3:0] ERR_ADC         = 4'hE;
    localparam logic [3:0] ERR_OVERFLOW    = 4'hF;

    // Status byte layout.
    localparam logic [1:0] STAT_FIXED      = 2'h1;
    localparam int         STAT_READY_BIT  = 5;

    // Top speed limits in pulses per second and value after reset.
    localparam logic [13:0] TOP_SPEED_MIN  = 14'h0001;
    localparam logic [13:0] TOP_SPEED_MAX  = 14'h2EE0;
    localparam logic [13:0] TOP_SPEED_RST  = 14'h0578;

    // Values after reset.
    localparam logic [3:0] ERR_RST         = 4'h0;
    localparam logic [7:0] STAT_RST        = 8'h60;

endpackage

// File: rtl/pump_error_status_handler.sv
// Operation
// (R1) Valve step loss latches code 10
// (R2) Valve command after valve overload re-homes first
// (R3) Plunger move in bypass rejected, code 11
// (R4) Internal failure 12, converter failure 14
// (R5) Codes 2 and 3 immediate, no reinit
// (R6) Init failed or missing blocks commands
// (R7) Uninitialized pump reports code 7 on move
// (R8) Host queries after init until ready
// (R9) Unrecovered overload repeats on next move
// (R10) Query clears overload, else reports init error
// (R11) Busy move, valve, set gives code 15
// (R12) Report, control, top speed accepted while moving
// (R13) Status byte 01, ready, 0, code
// (R14) Overflow encoded as code 15
// (R15) Bad command executes nothing, stays not busy
// (R16) Bypass error clears on next query
// (R17) Bit 5 shows ready or busy
// (R18) Any error halts and flushes commands
// (R19) Newest error overwrites latched code
// (R20) Codes 4, 5, 13 never reported
`timescale 1ns/10ps

module pump_error_status_handler (
    // Clock and reset.
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    // Decoded command from the parser.
    input  wire logic                     cmd_valid_i,
    input  wire pump_err_pkg::cmd_t       cmd_i,
    // Fault and completion pulses, mechanism levels.
    input  wire pump_err_pkg::fault_t     fault_i,
    input  wire logic                     plunger_moving_i,
    input  wire logic                     valve_bypass_i,
    // Reply to the host.
    output logic                          reply_valid_o,
    output logic [7:0]                    reply_byte_o,
    output logic [7:0]                    status_byte_o,
    output logic                          ready_o,
    // Execution requests to the motion logic.
    output logic                          exec_valid_o,
    output pump_err_pkg::cmd_class_t      exec_cls_o,
    output logic                          valve_rehome_o,
    output logic                          flush_o,
    output logic [13:0]                   top_speed_o
);
    import pump_err_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State and decision signals.

    logic       init_ok_r;
    logic [3:0] err_code_r;
    logic [3:0] ovl_code_r;
    logic       ovl_latched;
    logic       valve_pend;
    logic       init_busy;
    logic       busy;
    logic       any_fault;
    logic       gated;
    logic       exec_nxt;
    logic       rehome_nxt;
    logic       err_load;
    logic [3:0] code_nxt;
    logic [3:0] reply_code;
    logic [3:0] query_code;
    logic [3:0] fault_code;
    logic [7:0] reply_fmt;
    logic [7:0] status_fmt;

    // Pump is busy while the plunger moves or an init runs.
    assign busy = plunger_moving_i | init_busy; // see (R17)
    assign gated = (cmd_i.cls == CMD_MOVE) | (cmd_i.cls == CMD_VALVE)
                 | (cmd_i.cls == CMD_SET);
    assign any_fault = fault_i.init_fail | fault_i.plunger_ovl
                     | fault_i.valve_ovl | fault_i.eeprom_fail
                     | fault_i.internal_fail | fault_i.adc_fail;

    ////////////////////////////////////////////////////////////////////////
    // Latched conditions.

    // Overload stays until a successful init.
    sticky_flag u_ovl (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (fault_i.plunger_ovl | fault_i.valve_ovl),
        .clr_i     (fault_i.init_ok),
        .flag_o    (ovl_latched)
    );

    // Valve needs re-homing until a valve command or a successful init.
    sticky_flag u_valve (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (fault_i.valve_ovl),
        .clr_i     (rehome_nxt | fault_i.init_ok),
        .flag_o    (valve_pend)
    );

    // Init in progress from its start to its outcome.
    sticky_flag u_init (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (exec_nxt && cmd_i.cls == CMD_INIT),
        .clr_i     (fault_i.init_ok | fault_i.init_fail),
        .flag_o    (init_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Query answer and fault code selection.

    // A query retires immediate errors and overloads.
    always_comb begin
        case (err_code_r)
            ERR_PLUNGER_OVL,
            ERR_VALVE_OVL:   query_code = init_ok_r ? ERR_NONE
                                                    : ERR_INIT; // see (R10)
            ERR_BAD_CMD,
            ERR_BAD_OPERAND,
            ERR_NO_PLUNGER:  query_code = ERR_NONE; // see (R5) (R16)
            default:         query_code = err_code_r;
        endcase
    end

    // Later entries win when faults coincide.
    always_comb begin
        fault_code = ERR_NONE; // see (R20)
        if (fault_i.init_fail)     fault_code = ERR_INIT; // see (R6)
        if (fault_i.plunger_ovl)   fault_code = ERR_PLUNGER_OVL;
        if (fault_i.valve_ovl)     fault_code = ERR_VALVE_OVL; // see (R1)
        if (fault_i.eeprom_fail)   fault_code = ERR_EEPROM;
        if (fault_i.internal_fail) fault_code = ERR_FAILURE; // see (R4)
        if (fault_i.adc_fail)      fault_code = ERR_ADC; // see (R4)
    end

    ////////////////////////////////////////////////////////////////////////
    // Command verdict.

    // Decides whether a command runs, is refused, or raises an error.
    always_comb begin
        exec_nxt   = 1'b0;
        rehome_nxt = 1'b0;
        err_load   = 1'b0;
        code_nxt   = err_code_r;
        if (cmd_valid_i) begin
            if (cmd_i.cls == CMD_BAD) begin
                err_load = 1'b1;
                code_nxt = ERR_BAD_CMD; // see (R15)
            end else if (!cmd_i.operand_ok) begin
                err_load = 1'b1;
                code_nxt = ERR_BAD_OPERAND; // see (R5)
            end else begin
                case (cmd_i.cls)
                    CMD_QUERY: begin
                        code_nxt = query_code;
                    end
                    CMD_REPORT,
                    CMD_CONTROL: begin
                        exec_nxt = 1'b1; // see (R12)
                    end
                    CMD_TOP_SPEED: begin
                        if (cmd_i.value < TOP_SPEED_MIN
                                || cmd_i.value > TOP_SPEED_MAX) begin
                            err_load = 1'b1;
                            code_nxt = ERR_BAD_OPERAND;
                        end else begin
                            exec_nxt = 1'b1; // see (R12)
                        end
                    end
                    CMD_INIT: begin
                        if (busy) begin
                            err_load = 1'b1;
                            code_nxt = ERR_OVERFLOW;
                        end else begin
                            exec_nxt = 1'b1;
                        end
                    end
                    default: begin
                        if (busy) begin
                            err_load = 1'b1;
                            code_nxt = ERR_OVERFLOW; // see (R11) (R14)
                        end else if (ovl_latched) begin
                            if (cmd_i.cls == CMD_VALVE && valve_pend) begin
                                exec_nxt   = 1'b1;
                                rehome_nxt = 1'b1; // see (R2)
                            end else begin
                                err_load = 1'b1;
                                code_nxt = ovl_code_r; // see (R9) (R1)
                            end
                        end else if (!init_ok_r) begin
                            err_load = 1'b1;
                            code_nxt = ERR_NOT_INIT; // see (R6) (R7)
                        end else if (cmd_i.cls == CMD_MOVE
                                     && valve_bypass_i) begin
                            err_load = 1'b1;
                            code_nxt = ERR_NO_PLUNGER; // see (R3)
                        end else begin
                            exec_nxt = 1'b1;
                        end
                    end
                endcase
            end
        end
        // Faults override any command outcome in the same cycle.
        if (any_fault) begin
            exec_nxt   = 1'b0;
            rehome_nxt = 1'b0;
            err_load   = 1'b1;
            code_nxt   = fault_code; // see (R19)
        end else if (fault_i.init_ok && !err_load) begin
            code_nxt = ERR_NONE;
        end
    end

    // Reply carries the code decided for this command.
    assign reply_code = code_nxt;

    status_byte_fmt u_reply_fmt (
        .ready_i (~busy),
        .code_i  (reply_code),
        .byte_o  (reply_fmt)
    );

    status_byte_fmt u_status_fmt (
        .ready_i (~busy),
        .code_i  (code_nxt),
        .byte_o  (status_fmt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Error latch.

    // Newest error replaces the stored code.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            err_code_r <= ERR_RST;
        end else begin
            err_code_r <= code_nxt; // see (R19)
        end
    end

    // Remembers which overload to repeat on the next move.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ovl_code_r <= ERR_PLUNGER_OVL;
        end else if (fault_i.valve_ovl) begin
            ovl_code_r <= ERR_VALVE_OVL;
        end else if (fault_i.plunger_ovl) begin
            ovl_code_r <= ERR_PLUNGER_OVL;
        end
    end

    // Successful init arms the pump; failure or overload disarms it.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            init_ok_r <= 1'b0;
        end else if (fault_i.init_fail | fault_i.plunger_ovl
                     | fault_i.valve_ovl) begin
            init_ok_r <= 1'b0; // see (R6) (R10)
        end else if (fault_i.init_ok) begin
            init_ok_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers.

    // Reply byte and standing status byte.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reply_valid_o <= 1'b0;
            reply_byte_o  <= STAT_RST;
            status_byte_o <= STAT_RST;
            ready_o       <= 1'b1;
        end else begin
            reply_valid_o <= cmd_valid_i;
            if (cmd_valid_i) begin
                reply_byte_o <= reply_fmt; // see (R5)
            end
            status_byte_o <= status_fmt; // see (R13)
            ready_o       <= ~busy; // see (R17)
        end
    end

    // Execution strobes and flush on any error.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            exec_valid_o   <= 1'b0;
            exec_cls_o     <= CMD_QUERY;
            valve_rehome_o <= 1'b0;
            flush_o        <= 1'b0;
        end else begin
            exec_valid_o   <= exec_nxt;
            exec_cls_o     <= cmd_i.cls;
            valve_rehome_o <= rehome_nxt;
            flush_o        <= err_load; // see (R18)
        end
    end

    // Top speed may change while the plunger moves.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            top_speed_o <= TOP_SPEED_RST;
        end else if (exec_nxt && cmd_i.cls == CMD_TOP_SPEED) begin
            top_speed_o <= cmd_i.value; // see (R12)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    logic cmd_ok;
    assign cmd_ok = cmd_valid_i && cmd_i.operand_ok && !any_fault
                  && !fault_i.init_ok;

    AST_VALVE_OVL: assert property ( // see (R1)
        fault_i.valve_ovl && !fault_i.eeprom_fail && !fault_i.internal_fail
        && !fault_i.adc_fail |=> status_byte_o[3:0] == ERR_VALVE_OVL)
        else $error("Valve overload code not latched.");

    AST_REHOME: assert property ( // see (R2)
        cmd_ok && cmd_i.cls == CMD_VALVE && !busy && ovl_latched
        && valve_pend |=> valve_rehome_o && exec_valid_o)
        else $error("Valve command after overload did not re-home.");

    AST_BYPASS: assert property ( // see (R3)
        cmd_ok && cmd_i.cls == CMD_MOVE && !busy && init_ok_r
        && !ovl_latched && valve_bypass_i
        |=> reply_byte_o[3:0] == ERR_NO_PLUNGER && !exec_valid_o)
        else $error("Plunger move in bypass not rejected.");

    AST_QUERY_CLEAR: assert property ( // see (R16)
        cmd_ok && cmd_i.cls == CMD_QUERY && err_code_r == ERR_NO_PLUNGER
        |=> reply_byte_o[3:0] == ERR_NONE && status_byte_o[3:0] == ERR_NONE)
        else $error("Query after immediate error still reports it.");

    AST_NOT_INIT: assert property ( // see (R7)
        cmd_ok && cmd_i.cls == CMD_MOVE && !busy && !init_ok_r
        && !ovl_latched |=> reply_byte_o[3:0] == ERR_NOT_INIT)
        else $error("Move without init did not report code 7.");

    AST_OVERFLOW: assert property ( // see (R11)
        cmd_ok && gated && plunger_moving_i
        |=> reply_byte_o[3:0] == ERR_OVERFLOW && !exec_valid_o && flush_o)
        else $error("Command while moving did not overflow.");

    AST_TOP_SPEED: assert property ( // see (R12)
        cmd_ok && cmd_i.cls == CMD_TOP_SPEED && cmd_i.value != 14'h0000
        && cmd_i.value <= TOP_SPEED_MAX
        |=> exec_valid_o && top_speed_o == $past(cmd_i.value))
        else $error("Top speed not accepted during move.");

    AST_BYTE_FORM: assert property ( // see (R13)
        status_byte_o[7:6] == STAT_FIXED && !status_byte_o[4]
        && status_byte_o[STAT_READY_BIT] == ready_o)
        else $error("Status byte layout broken.");

    AST_NO_UNUSED: assert property ( // see (R20)
        reply_valid_o |-> !(reply_byte_o[3:0] inside {4'h4, 4'h5, 4'hD}))
        else $error("Unused error code reported.");

    AST_BAD_CMD: assert property ( // see (R15)
        cmd_valid_i && cmd_i.cls == CMD_BAD && !any_fault
        |=> reply_byte_o[3:0] == ERR_BAD_CMD && !exec_valid_o)
        else $error("Invalid command was executed.");

    AST_OVL_QUERY: assert property ( // see (R10)
        cmd_ok && cmd_i.cls == CMD_QUERY && !init_ok_r
        && err_code_r == ERR_PLUNGER_OVL |=> reply_byte_o[3:0] == ERR_INIT)
        else $error("Query after overload did not report init error.");

    AST_FLUSH: assert property ( // see (R18)
        any_fault |=> flush_o && !exec_valid_o)
        else $error("Fault did not flush commands.");

    COV_OVERFLOW: cover property (cmd_ok && gated && plunger_moving_i);
    COV_REHOME:   cover property (rehome_nxt);
    COV_INIT_OK:  cover property (fault_i.init_ok ##[1:20] exec_valid_o);

endmodule

// File: rtl/status_byte_fmt.sv
`timescale 1ns/10ps

// Builds the status byte from the ready flag and an error code.
module status_byte_fmt (
    // Status fields.
    input  wire logic       ready_i,
    input  wire logic [3:0] code_i,
    // Assembled byte.
    output logic [7:0]      byte_o
);
    import pump_err_pkg::*;

    // Bits 7..6 fixed, bit 5 ready, bit 4 zero, low nibble the code.
    always_comb begin
        byte_o = {STAT_FIXED, ready_i, 1'b0, code_i}; // see (R13) (R14)
    end

endmodule

// File: rtl/sticky_flag.sv
`timescale 1ns/10ps

// Event flag that holds until cleared; a set in the clear cycle wins.
module sticky_flag (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // Set and clear strobes.
    input  wire logic set_i,
    input  wire logic clr_i,
    // Flag state.
    output logic      flag_o
);

    // Set has priority so an event never gets lost.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end

endmodule

// File: tb/host_model.sv
`timescale 1ns/10ps

// Host side of the command link: one decoded command per call.
module host_model (
    // Clock.
    input  wire logic         clk_i,
    // Command towards the handler.
    output logic              cmd_valid_o,
    output pump_err_pkg::cmd_t cmd_o
);
    import pump_err_pkg::*;

    // The bus starts idle.
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
    end

    // Present a command for one cycle, then scramble the idle bus.
    task automatic send(input cmd_t c);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o       <= c;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o       <= cmd_t'(~c);
        #1;
    endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps

module testbench;
    import pump_err_pkg::*;

    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    fault_t     fault = '0;
    logic       moving = 1'b0;
    logic       bypass = 1'b0;
    logic       cmd_valid;
    cmd_t       cmd;
    logic       reply_valid;
    logic [7:0] reply_byte;
    logic [7:0] status_byte;
    logic       ready;
    logic       exec_valid;
    cmd_class_t exec_cls;
    logic       rehome;
    logic       flush;
    logic [13:0] top_speed;
    int         error_cnt = 0;
    int         samples_checked = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock at 100 ns and the two parties.
    initial begin
        forever #50 clk = ~clk;
    end

    host_model host (.clk_i(clk), .cmd_valid_o(cmd_valid), .cmd_o(cmd));

    pump_error_status_handler DUT (
        .clk_i(clk), .sys_rst_i(sys_rst), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .fault_i(fault), .plunger_moving_i(moving),
        .valve_bypass_i(bypass), .reply_valid_o(reply_valid),
        .reply_byte_o(reply_byte), .status_byte_o(status_byte),
        .ready_o(ready), .exec_valid_o(exec_valid), .exec_cls_o(exec_cls),
        .valve_rehome_o(rehome), .flush_o(flush), .top_speed_o(top_speed)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic chk_val(input string name, input logic [13:0] exp,
                           input logic [13:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Send a command; a negative expectation is not compared.
    task automatic do_cmd(input cmd_class_t cls, input logic ok,
                          input logic [13:0] val, input int rep,
                          input int ex);
        host.send('{cls: cls, operand_ok: ok, value: val});
        chk_val("reply_valid", 14'h0001, 14'(reply_valid));
        if (rep >= 0) chk_val("reply_byte", 14'(rep), 14'(reply_byte));
        if (ex >= 0) begin
            chk_val("exec_valid", 14'(ex), 14'(exec_valid));
            chk_val("flush", 14'(1 - ex), 14'(flush));
            if (ex == 1) chk_val("exec_cls", 14'(cls), 14'(exec_cls));
        end
    endtask

    // Pulse fault lines for one cycle and check the latched code.
    task automatic do_fault(input logic [6:0] f, input logic [3:0] code,
                            input logic fl);
        @(posedge clk);
        fault <= fault_t'(f);
        @(posedge clk);
        fault <= '0;
        #1;
        chk_val("status_code", 14'(code), 14'(status_byte[3:0]));
        chk_val("flush", 14'(fl), 14'(flush));
    endtask

    // Let level inputs settle through the registers.
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset;
        chk_val("status_byte", 14'h0060, 14'(status_byte));
        chk_val("ready", 14'h0001, 14'(ready));
        chk_val("top_speed", 14'h0578, top_speed);
    endtask

    task automatic t_uninit;
        do_cmd(CMD_MOVE, 1'b1, 14'h0010, 8'h67, 0);
        do_cmd(CMD_VALVE, 1'b1, 14'h0002, 8'h67, 0);
        do_cmd(CMD_SET, 1'b1, 14'h0002, -1, 0);
    endtask

    task automatic t_init;
        do_cmd(CMD_INIT, 1'b1, 14'h0000, 8'h67, 1);
        settle();
        chk_val("status_byte", 14'h0047, 14'(status_byte));
        do_fault(7'h40, 4'h0, 1'b0);
        do_cmd(CMD_QUERY, 1'b1, 14'h0000, 8'h60, -1);
        do_cmd(CMD_MOVE, 1'b1, 14'h0100, 8'h60, 1);
    endtask

    task automatic t_busy;
        cmd_class_t refused[4] = '{CMD_MOVE, CMD_VALVE, CMD_SET, CMD_INIT};
        @(posedge clk);
        moving <= 1'b1;
        settle();
        chk_val("status_byte", 14'h0040, 14'(status_byte));
        foreach (refused[i]) begin
            do_cmd(refused[i], 1'b1, 14'h0005, 8'h4F, 0);
        end
        chk_val("status_byte", 14'h004F, 14'(status_byte));
        do_cmd(CMD_REPORT, 1'b1, 14'h0001, -1, 1);
        do_cmd(CMD_CONTROL, 1'b1, 14'h0001, -1, 1);
        do_cmd(CMD_TOP_SPEED, 1'b1, 14'h2EE0, -1, 1);
        chk_val("top_speed", 14'h2EE0, top_speed);
        @(posedge clk);
        moving <= 1'b0;
        settle();
        chk_val("status_byte", 14'h006F, 14'(status_byte));
    endtask

    task automatic t_immediate;
        do_cmd(CMD_BAD, 1'b1, 14'h0000, 8'h62, 0);
        chk_val("ready", 14'h0001, 14'(ready));
        do_cmd(CMD_QUERY, 1'b1, 14'h0000, 8'h60, -1);
        do_cmd(CMD_MOVE, 1'b0, 14'h0001, 8'h63, 0);
        do_cmd(CMD_MOVE, 1'b1, 14'h0001, 8'h63, 1);
        do_cmd(CMD_TOP_SPEED, 1'b1, 14'h0000, 8'h63, 0);
        do_cmd(CMD_TOP_SPEED, 1'b1, 14'h2EE1, 8'h63, 0);
        chk_val("top_speed", 14'h2EE0, top_speed);
        do_cmd(CMD_TOP_SPEED, 1'b1, 14'h0001, 8'h63, 1);
        chk_val("top_speed", 14'h0001, top_speed);
    endtask

    task automatic t_bypass;
        @(posedge clk);
        bypass <= 1'b1;
        settle();
        do_cmd(CMD_MOVE, 1'b1, 14'h0001, 8'h6B, 0);
        do_cmd(CMD_QUERY, 1'b1, 14'h0000, 8'h60, -1);
        @(posedge clk);
        bypass <= 1'b0;
        settle();
    endtask

    task automatic t_overload;
        do_fault(7'h08, 4'hA, 1'b1);
        do_cmd(CMD_MOVE, 1'b1, 14'h0001, 8'h6A, 0);
        do_cmd(CMD_VALVE, 1'b1, 14'h0003, -1, 1);
        chk_val("valve_rehome", 14'h0001, 14'(rehome));
        do_fault(7'h10, 4'h9, 1'b1);
        do_cmd(CMD_MOVE, 1'b1, 14'h0001, 8'h69, 0);
        do_cmd(CMD_QUERY, 1'b1, 14'h0000, 8'h61, -1);
        do_fault(7'h11, 4'hE, 1'b1);
        do_fault(7'h02, 4'hC, 1'b1);
        do_fault(7'h04, 4'h6, 1'b1);
        do_fault(7'h20, 4'h1, 1'b1);
        do_cmd(CMD_MOVE, 1'b1, 14'h0001, 8'h69, 0);
        do_fault(7'h40, 4'h0, 1'b0);
        do_cmd(CMD_QUERY, 1'b1, 14'h0000, 8'h60, -1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Unused codes must never show in the status byte.
    always @(negedge clk) begin
        if (!sys_rst && status_byte[3:0] inside {4'h4, 4'h5,
                                                 4'hD}) begin
            error_cnt++;
            $display("Error status_code expected legal seen %h", status_byte);
        end
    end

    // Verdict and end of run.
    task automatic conclude;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 110 cycles of the sequence.
    initial begin
        #(3000 * 100);
        error_cnt++;
        conclude();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        t_reset();
        t_uninit();
        t_init();
        t_busy();
        t_immediate();
        t_bypass();
        t_overload();
        conclude();
    end
endmodule
